// ---- csp_clock_ctrl.sv ----
// Clock generation control: protection, lock, source, divider, PLL and oscillator monitor.
// ----------------------------------------
// Functional notes
// ----------------------------------------
// Functional notes
// RULE_01: Mode register 2 writable only when pm-protect set.
// RULE_02: PLL wait select changeable only with PLL off.
// RULE_03: Software stops PLL before changing wait select.
// RULE_04: Clock change lock cannot be cleared by software.
// RULE_05: Lock freezes listed clock control bits.
// RULE_06: Software avoids wait instruction while locked.
// RULE_07: Watchdog ring source starts ring, counts through wait.
// RULE_08: Watchdog ring source blocks stop mode request.
// RULE_09: PLL and peripheral registers need clk-protect.
// RULE_10: Lock blocks all PLL control writes.
// RULE_11: Multiplier written once, only with PLL off.
// RULE_12: Software selects main undivided before PLL on.
// RULE_13: Reset selects main clock divided by eight.
// RULE_14: Stop mode halts clocks, opens feedback resistors.
// RULE_15: Sub clock off after reset, selected by software.
// RULE_16: Ring select starts ring, replaces main clock.
// RULE_17: Monitored main stop starts ring automatically.
// RULE_18: PLL starts on enable; software waits settle.
// RULE_19: Software leaves PLL before wait or stop.
// RULE_20: PLL output is main times chosen factor.
// RULE_21: Main or ring divided by 1,2,4,8,16.
// RULE_22: Software keeps dividers undivided when PLL used.
// RULE_23: Hardware forces divide-by-eight on stop or low power.
// RULE_24: Monitor event sets flag; software clears with zero.
// RULE_25: Blocked writes leave affected bits unchanged.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module csp_clock_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Oscillator status
	input wire logic mainOscStopped,
	input wire logic oscEvent,
	input wire logic subOscStable,
	input wire logic stopExit,
	// Clock control outputs
	output logic [1:0] cpuClkSrc,
	output logic [2:0] cpuClkDiv,
	output logic [3:0] pllFactor,
	output logic pllEnable,
	output logic mainOscEnable,
	output logic subOscEnable,
	output logic ringOscEnable,
	output logic feedbackEnable,
	output logic stopMode,
	output logic wdtRingSource,
	output logic periphStopInWait,
	output logic pllWaitSel,
	output logic oscEventIrq
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] protect;
		logic [7:0] mode2;
		logic [7:0] pllCtrl;
		logic [7:0] periph;
		logic [7:0] cm0;
		logic [7:0] cm1;
		logic [7:0] cm2;
		logic multWritten;
		logic stop;
		logic [7:0] rdData;
	} csp_state_s;

	csp_state_s st_q;
	csp_state_s st_d;

	csp_if sel ();

	logic locked;
	logic wrProtect;
	logic wrMode2;
	logic wrPll;
	logic wrPeriph;
	logic wrCm0;
	logic wrCm1;
	logic wrCm2;
	logic mainStopSeen;

	assign locked = st_q.mode2[csp_pkg::CLK_CHANGE_LOCK];
	assign mainStopSeen = oscEvent & mainOscStopped;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	always_comb begin
		wrProtect = 1'b0;
		wrMode2 = 1'b0;
		wrPll = 1'b0;
		wrPeriph = 1'b0;
		wrCm0 = 1'b0;
		wrCm1 = 1'b0;
		wrCm2 = 1'b0;
		if (regWrite && regAddr == csp_pkg::ADDR_PROTECT) begin
			wrProtect = 1'b1;
		end else if (regWrite && regAddr == csp_pkg::ADDR_MODE2) begin
			wrMode2 = st_q.protect[csp_pkg::PM_PROTECT_BIT]; // RULE_01
		end else if (regWrite && regAddr == csp_pkg::ADDR_PLLCTRL) begin
			wrPll = st_q.protect[csp_pkg::CLK_PROTECT_BIT] & ~locked; // RULE_09 RULE_10
		end else if (regWrite && regAddr == csp_pkg::ADDR_PERIPH) begin
			wrPeriph = st_q.protect[csp_pkg::CLK_PROTECT_BIT]; // RULE_09
		end else if (regWrite && regAddr == csp_pkg::ADDR_CLKCTRL0) begin
			wrCm0 = st_q.protect[csp_pkg::CLK_PROTECT_BIT];
		end else if (regWrite && regAddr == csp_pkg::ADDR_CLKCTRL1) begin
			wrCm1 = st_q.protect[csp_pkg::CLK_PROTECT_BIT];
		end else if (regWrite && regAddr == csp_pkg::ADDR_CLKCTRL2) begin
			wrCm2 = st_q.protect[csp_pkg::CLK_PROTECT_BIT];
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		if (clkEn) begin
			if (wrProtect) begin
				st_d.protect = {6'h00, regWrData[1:0]};
			end
			// Blocked fields keep their old value; only accepted bits are replaced.
			if (wrMode2) begin // RULE_25
				if (!st_q.pllCtrl[csp_pkg::PLL_ON]) begin
					st_d.mode2[csp_pkg::PLL_WAIT_SEL] = regWrData[csp_pkg::PLL_WAIT_SEL]; // RULE_02
				end
				st_d.mode2[csp_pkg::CLK_CHANGE_LOCK] = locked | regWrData[csp_pkg::CLK_CHANGE_LOCK]; // RULE_04
				st_d.mode2[csp_pkg::WDT_RING_SRC] = regWrData[csp_pkg::WDT_RING_SRC];
			end
			if (wrPll) begin
				st_d.pllCtrl[csp_pkg::PLL_ON] = regWrData[csp_pkg::PLL_ON]; // RULE_18
				if (!st_q.pllCtrl[csp_pkg::PLL_ON] && !st_q.multWritten) begin
					st_d.pllCtrl[2:0] = regWrData[2:0]; // RULE_11
					st_d.multWritten = 1'b1;
				end
			end
			if (wrPeriph) begin
				st_d.periph = {6'h00, regWrData[1:0]};
			end
			if (wrCm0) begin
				st_d.cm0[csp_pkg::DIV8_SEL] = regWrData[csp_pkg::DIV8_SEL];
				if (!locked) begin // RULE_05
					st_d.cm0[csp_pkg::PERIPH_STOP_IN_WAIT] = regWrData[csp_pkg::PERIPH_STOP_IN_WAIT];
					st_d.cm0[csp_pkg::MAIN_OSC_OFF] = regWrData[csp_pkg::MAIN_OSC_OFF];
					st_d.cm0[csp_pkg::SUB_CLK_SEL] = regWrData[csp_pkg::SUB_CLK_SEL]; // RULE_15
					// Turning the main oscillator off in low speed mode forces divide by eight.
					if (regWrData[csp_pkg::MAIN_OSC_OFF] && st_q.cm0[csp_pkg::SUB_CLK_SEL]) begin
						st_d.cm0[csp_pkg::DIV8_SEL] = 1'b1; // RULE_23
					end
				end
			end
			if (wrCm1) begin
				st_d.cm1[7:6] = regWrData[7:6]; // RULE_21
				if (!locked) begin // RULE_05
					st_d.cm1[csp_pkg::PLL_CPU_SEL] = regWrData[csp_pkg::PLL_CPU_SEL];
					if (!st_q.mode2[csp_pkg::WDT_RING_SRC]) begin // RULE_08
						st_d.cm1[csp_pkg::STOP_MODE_REQ] = regWrData[csp_pkg::STOP_MODE_REQ];
					end
				end
			end
			if (wrCm2) begin
				st_d.cm2[csp_pkg::RING_CLK_SEL] = regWrData[csp_pkg::RING_CLK_SEL]; // RULE_16
				st_d.cm2[csp_pkg::OSC_EVENT_ACTION] = regWrData[csp_pkg::OSC_EVENT_ACTION];
				if (!locked) begin // RULE_05
					st_d.cm2[csp_pkg::OSC_MONITOR_EN] = regWrData[csp_pkg::OSC_MONITOR_EN];
				end
				if (!regWrData[csp_pkg::OSC_EVENT_FLAG]) begin // RULE_24
					st_d.cm2[csp_pkg::OSC_EVENT_FLAG] = 1'b0;
				end
			end
			// A detected event wins over a clear in the same cycle.
			if (oscEvent && st_q.cm2[csp_pkg::OSC_MONITOR_EN]) begin
				st_d.cm2[csp_pkg::OSC_EVENT_FLAG] = 1'b1; // RULE_24
			end
			if (mainStopSeen && st_q.cm2[csp_pkg::OSC_MONITOR_EN] && st_q.cm2[csp_pkg::OSC_EVENT_ACTION] &&
				!st_q.cm1[csp_pkg::PLL_CPU_SEL] && !st_q.cm0[csp_pkg::SUB_CLK_SEL]) begin
				st_d.cm2[csp_pkg::RING_CLK_SEL] = 1'b1; // RULE_17
			end
			// Stop mode is entered from the request bit and left on an exit event.
			if (st_q.cm1[csp_pkg::STOP_MODE_REQ] && !st_q.stop) begin
				st_d.stop = 1'b1; // RULE_14
				st_d.cm1[csp_pkg::STOP_MODE_REQ] = 1'b0;
				if (!st_q.cm0[csp_pkg::SUB_CLK_SEL]) begin
					st_d.cm0[csp_pkg::DIV8_SEL] = 1'b1; // RULE_23
				end
			end else if (st_q.stop && stopExit) begin
				st_d.stop = 1'b0;
			end
			if (regRead) begin
				if (regAddr == csp_pkg::ADDR_PROTECT) begin
					st_d.rdData = st_q.protect;
				end else if (regAddr == csp_pkg::ADDR_MODE2) begin
					st_d.rdData = st_q.mode2;
				end else if (regAddr == csp_pkg::ADDR_PLLCTRL) begin
					st_d.rdData = st_q.pllCtrl;
				end else if (regAddr == csp_pkg::ADDR_PERIPH) begin
					st_d.rdData = st_q.periph;
				end else if (regAddr == csp_pkg::ADDR_CLKCTRL0) begin
					st_d.rdData = st_q.cm0;
				end else if (regAddr == csp_pkg::ADDR_CLKCTRL1) begin
					st_d.rdData = st_q.cm1;
				end else if (regAddr == csp_pkg::ADDR_CLKCTRL2) begin
					st_d.rdData = st_q.cm2 | {4'h0, mainOscStopped, 3'h0};
				end else if (regAddr == csp_pkg::ADDR_STATUS) begin
					st_d.rdData = {1'b0, st_q.stop, sel.srcOut, 1'b0, sel.divOut};
				end else begin
					st_d.rdData = 8'h00;
				end
			end else begin
				st_d.rdData = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{protect: 8'h00, mode2: csp_pkg::RST_MODE2, pllCtrl: csp_pkg::RST_PLLCTRL,
				periph: csp_pkg::RST_PERIPH, cm0: csp_pkg::RST_CLKCTRL0, cm1: csp_pkg::RST_CLKCTRL1,
				cm2: csp_pkg::RST_CLKCTRL2, multWritten: 1'b0, stop: 1'b0, rdData: 8'h00}; // RULE_13
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Source and divider selection
	// ----------------------------------------
	always_comb begin
		if (st_q.cm0[csp_pkg::SUB_CLK_SEL]) begin
			sel.src = 2'(csp_pkg::CSP_SRC_SUB);
		end else if (st_q.cm2[csp_pkg::RING_CLK_SEL]) begin
			sel.src = 2'(csp_pkg::CSP_SRC_RING); // RULE_16
		end else if (st_q.cm1[csp_pkg::PLL_CPU_SEL]) begin
			sel.src = 2'(csp_pkg::CSP_SRC_PLL);
		end else begin
			sel.src = 2'(csp_pkg::CSP_SRC_MAIN);
		end
		if (st_q.cm0[csp_pkg::DIV8_SEL]) begin // RULE_21
			sel.divSel = csp_pkg::DIV_8;
		end else begin
			case (st_q.cm1[7:6])
				2'h0: sel.divSel = csp_pkg::DIV_1;
				2'h1: sel.divSel = csp_pkg::DIV_2;
				2'h2: sel.divSel = csp_pkg::DIV_4;
				default: sel.divSel = csp_pkg::DIV_16;
			endcase
		end
	end

	assign sel.multSel = st_q.pllCtrl[2:0];
	// The next stop state is fed so that the factor drops on the same edge on which stop mode starts.
	assign sel.stopAll = st_d.stop;

	csp_clock_select u_select (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.sl(sel)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdData = st_q.rdData;
	assign cpuClkSrc = sel.srcOut;
	assign cpuClkDiv = sel.divOut;
	assign pllFactor = sel.multFactor; // RULE_20
	assign pllEnable = st_q.pllCtrl[csp_pkg::PLL_ON] & ~st_q.stop; // RULE_14 RULE_18
	assign mainOscEnable = ~st_q.cm0[csp_pkg::MAIN_OSC_OFF] & ~st_q.stop; // RULE_14
	assign subOscEnable = st_q.cm0[csp_pkg::SUB_CLK_SEL] & ~st_q.stop; // RULE_15
	// Ring runs for the CPU, for the watchdog, or after a main clock failure.
	// It keeps running until the registered selector has left it, so the CPU loses its clock only in stop mode.
	assign ringOscEnable = (st_q.cm2[csp_pkg::RING_CLK_SEL] | st_q.mode2[csp_pkg::WDT_RING_SRC] |
		(sel.srcOut == 2'(csp_pkg::CSP_SRC_RING))) & ~st_q.stop; // RULE_07 RULE_16 RULE_17
	assign feedbackEnable = ~st_q.stop; // RULE_14
	assign stopMode = st_q.stop;
	assign wdtRingSource = st_q.mode2[csp_pkg::WDT_RING_SRC]; // RULE_07
	assign periphStopInWait = st_q.cm0[csp_pkg::PERIPH_STOP_IN_WAIT];
	assign pllWaitSel = st_q.mode2[csp_pkg::PLL_WAIT_SEL];
	assign oscEventIrq = st_d.cm2[csp_pkg::OSC_EVENT_FLAG] & ~st_q.cm2[csp_pkg::OSC_EVENT_FLAG]; // RULE_24

endmodule

// ---- csp_pkg.sv ----
// Package holding register offsets, field positions and reset values of the clock controller.
package csp_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_PROTECT = 4'h0;
	localparam logic [3:0] ADDR_MODE2 = 4'h1;
	localparam logic [3:0] ADDR_PLLCTRL = 4'h2;
	localparam logic [3:0] ADDR_PERIPH = 4'h3;
	localparam logic [3:0] ADDR_CLKCTRL0 = 4'h4;
	localparam logic [3:0] ADDR_CLKCTRL1 = 4'h5;
	localparam logic [3:0] ADDR_CLKCTRL2 = 4'h6;
	localparam logic [3:0] ADDR_STATUS = 4'h7;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CLK_PROTECT_BIT = 0;
	localparam int PM_PROTECT_BIT = 1;
	localparam int PLL_WAIT_SEL = 0;
	localparam int CLK_CHANGE_LOCK = 1;
	localparam int WDT_RING_SRC = 2;
	localparam int PLL_ON = 7;
	localparam int PERIPH_STOP_IN_WAIT = 2;
	localparam int MAIN_OSC_OFF = 5;
	localparam int DIV8_SEL = 6;
	localparam int SUB_CLK_SEL = 7;
	localparam int STOP_MODE_REQ = 0;
	localparam int PLL_CPU_SEL = 1;
	localparam int CPU_DIV_LSB = 6;
	localparam int OSC_MONITOR_EN = 0;
	localparam int RING_CLK_SEL = 1;
	localparam int OSC_EVENT_FLAG = 2;
	localparam int OSC_EVENT_ACTION = 7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MODE2 = 8'h01;
	localparam logic [7:0] RST_PLLCTRL = 8'h12;
	localparam logic [7:0] RST_PERIPH = 8'h03;
	localparam logic [7:0] RST_CLKCTRL0 = 8'h40;
	localparam logic [7:0] RST_CLKCTRL1 = 8'h20;
	localparam logic [7:0] RST_CLKCTRL2 = 8'h00;

	// ----------------------------------------
	// Clock source, divider and multiplier encodings
	// ----------------------------------------
	typedef enum logic [1:0] {CSP_SRC_MAIN, CSP_SRC_SUB, CSP_SRC_RING, CSP_SRC_PLL} csp_src_e;
	localparam logic [2:0] DIV_1 = 3'h0;
	localparam logic [2:0] DIV_2 = 3'h1;
	localparam logic [2:0] DIV_4 = 3'h2;
	localparam logic [2:0] DIV_8 = 3'h3;
	localparam logic [2:0] DIV_16 = 3'h4;
	localparam logic [2:0] MULT_2 = 3'h1;
	localparam logic [2:0] MULT_4 = 3'h2;
	localparam logic [2:0] MULT_6 = 3'h3;
	localparam logic [2:0] MULT_8 = 3'h4;

endpackage

// ---- csp_if.sv ----
// Interface carrying the decoded clock selection from the register file to the selector.
`timescale 1ns/1ps
interface csp_if;
	logic [1:0] src;
	logic [2:0] divSel;
	logic [2:0] multSel;
	logic stopAll;
	logic [1:0] srcOut;
	logic [2:0] divOut;
	logic [3:0] multFactor;

	modport ctrl (output src, output divSel, output multSel, output stopAll, input srcOut, input divOut, input multFactor);
	modport sel (input src, input divSel, input multSel, input stopAll, output srcOut, output divOut, output multFactor);
endinterface

// ---- csp_clock_select.sv ----
// Registered CPU clock source, divider and PLL factor selection.
`timescale 1ns/1ps
module csp_clock_select (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Selection
	csp_if.sel sl
);

	typedef struct packed {
		logic [1:0] src;
		logic [2:0] div;
		logic [3:0] mult;
	} csp_sel_s;

	csp_sel_s st_q;
	csp_sel_s st_d;

	always_comb begin
		st_d = st_q;
		if (clkEn) begin
			st_d.src = sl.src;
			// The PLL output is undivided, so its divider reads as one.
			st_d.div = (sl.src == 2'(csp_pkg::CSP_SRC_PLL) || sl.src == 2'(csp_pkg::CSP_SRC_SUB)) ?
				csp_pkg::DIV_1 : sl.divSel; // RULE_21
			case (sl.multSel) // RULE_20
				csp_pkg::MULT_2: st_d.mult = 4'h2;
				csp_pkg::MULT_4: st_d.mult = 4'h4;
				csp_pkg::MULT_6: st_d.mult = 4'h6;
				csp_pkg::MULT_8: st_d.mult = 4'h8;
				default: st_d.mult = 4'h0;
			endcase
			if (sl.stopAll) begin
				st_d.mult = 4'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{src: 2'h0, div: csp_pkg::DIV_8, mult: 4'h0};
		end else begin
			st_q <= st_d;
		end
	end

	assign sl.srcOut = st_q.src;
	assign sl.divOut = st_q.div;
	assign sl.multFactor = st_q.mult;

endmodule

// ---- csp_clock_ctrl_properties.sv ----
// Concurrent checks on the ports of the clock controller.
`timescale 1ns/1ps
module csp_clock_ctrl_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Observed signals
	input wire logic oscEvent,
	input wire logic [1:0] cpuClkSrc,
	input wire logic [2:0] cpuClkDiv,
	input wire logic [3:0] pllFactor,
	input wire logic pllEnable,
	input wire logic mainOscEnable,
	input wire logic subOscEnable,
	input wire logic ringOscEnable,
	input wire logic feedbackEnable,
	input wire logic stopMode,
	input wire logic wdtRingSource,
	input wire logic [3:0] regAddr,
	input wire logic regWrite,
	input wire logic oscEventIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_RST_CLK: assert property ($rose(rst_b) |-> cpuClkSrc == csp_pkg::CSP_SRC_MAIN && cpuClkDiv == csp_pkg::DIV_8)
		else $error("CPU clock after reset is not main divided by eight");
	AST_RST_OSC: assert property ($rose(rst_b) |-> !subOscEnable && !ringOscEnable && !pllEnable)
		else $error("Sub, ring or PLL running after reset");
	AST_STOP_HALT: assert property (stopMode |-> !feedbackEnable && !mainOscEnable && !subOscEnable && pllFactor == 4'h0)
		else $error("Clock or feedback still on in stop");
	AST_WDT_NO_STOP: assert property (wdtRingSource && !stopMode && regWrite && regAddr == csp_pkg::ADDR_CLKCTRL1
		|-> ##1 !stopMode ##1 !stopMode ##1 !stopMode)
		else $error("Stop entered while watchdog uses ring");
	AST_RING_SRC: assert property (cpuClkSrc == csp_pkg::CSP_SRC_RING && !stopMode |-> ringOscEnable)
		else $error("Ring selected but not running");
	AST_WDT_RING: assert property (wdtRingSource && !stopMode |-> ringOscEnable)
		else $error("Watchdog ring source without ring running");
	AST_PLL_SRC: assert property (cpuClkSrc == csp_pkg::CSP_SRC_PLL |-> pllEnable)
		else $error("PLL selected while PLL is off");
	AST_PLL_FACTOR: assert property (cpuClkSrc == csp_pkg::CSP_SRC_PLL && !stopMode
		|-> pllFactor inside {4'h2, 4'h4, 4'h6, 4'h8})
		else $error("PLL factor outside the legal set");
	AST_DIV_RANGE: assert property (cpuClkDiv <= csp_pkg::DIV_16)
		else $error("Divider code out of range");
	AST_IRQ_CAUSE: assert property (oscEventIrq |-> oscEvent)
		else $error("Monitor interrupt without monitor event");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	CV_STOP: cover property ($rose(stopMode));
	CV_PLL: cover property (cpuClkSrc == csp_pkg::CSP_SRC_PLL);
	CV_IRQ: cover property (oscEventIrq);
endmodule

// ---- clock_source_select_pll_lock_tb_top.sv ----
// Self-checking testbench of the clock controller.
`timescale 1ns/1ps
`define CHK(got, exp) begin nChecks++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module clock_source_select_pll_lock_tb_top;
	logic clk, rst_b, clkEn, regWrite, regRead, mainOscStopped, oscEvent, subOscStable, stopExit;
	logic [3:0] regAddr;
	logic [7:0] regWrData, regRdData, rdv;
	logic [1:0] cpuClkSrc;
	logic [2:0] cpuClkDiv;
	logic [3:0] pllFactor;
	logic pllEnable, mainOscEnable, subOscEnable, ringOscEnable, feedbackEnable, stopMode;
	logic wdtRingSource, periphStopInWait, pllWaitSel, oscEventIrq, d8;
	logic [1:0] code;
	int mismatches, nChecks;
	logic [3:0] addrs [5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
	logic [7:0] rsts [5] = '{csp_pkg::RST_MODE2, csp_pkg::RST_PLLCTRL, csp_pkg::RST_CLKCTRL0,
		csp_pkg::RST_CLKCTRL1, csp_pkg::RST_CLKCTRL2};

	csp_clock_ctrl u_dut (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .mainOscStopped(mainOscStopped),
		.oscEvent(oscEvent), .subOscStable(subOscStable), .stopExit(stopExit), .cpuClkSrc(cpuClkSrc),
		.cpuClkDiv(cpuClkDiv), .pllFactor(pllFactor), .pllEnable(pllEnable), .mainOscEnable(mainOscEnable),
		.subOscEnable(subOscEnable), .ringOscEnable(ringOscEnable), .feedbackEnable(feedbackEnable),
		.stopMode(stopMode), .wdtRingSource(wdtRingSource), .periphStopInWait(periphStopInWait),
		.pllWaitSel(pllWaitSel), .oscEventIrq(oscEventIrq));

	// ----------------------------------------
	// Bus tasks and expectations
	// ----------------------------------------
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		// Read data stand only in the cycle after the strobe.
		#1 rdv = regRdData;
	endtask

	// Outputs follow a write two edges later; one spare edge absorbs the strobe edge.
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	function automatic logic [2:0] expDiv(input logic e8, input logic [1:0] c);
		if (e8)
			return csp_pkg::DIV_8;
		case (c)
			2'h0: return csp_pkg::DIV_1;
			2'h1: return csp_pkg::DIV_2;
			2'h2: return csp_pkg::DIV_4;
			default: return csp_pkg::DIV_16;
		endcase
	endfunction

	task automatic wrapUp();
		if (mismatches == 0 && nChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrapUp();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{rst_b, regWrite, regRead, mainOscStopped, oscEvent, stopExit} = '0;
		{clkEn, subOscStable} = 2'h3;
		regAddr = 4'h0;
		regWrData = 8'h00;
		void'($urandom(32'h5420));
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		settle();
		`CHK(cpuClkDiv, csp_pkg::DIV_8)
		`CHK({subOscEnable, ringOscEnable, pllEnable}, 3'h0)
		// Without protection every random write must bounce off.
		for (int i = 0; i < 5; i++) begin
			rd(addrs[i]);
			`CHK(rdv, rsts[i])
			wr(addrs[i], 8'($urandom));
			rd(addrs[i]);
			`CHK(rdv, rsts[i])
		end
		rd(4'hF);
		`CHK(rdv, 8'h00)
		wr(csp_pkg::ADDR_PROTECT, 8'h03);
		wr(csp_pkg::ADDR_MODE2, 8'h00);
		rd(csp_pkg::ADDR_MODE2);
		`CHK(rdv, 8'h00)
		wr(csp_pkg::ADDR_MODE2, 8'h01);
		// With the clock enable low a write must not land.
		clkEn <= 1'b0;
		wr(csp_pkg::ADDR_MODE2, 8'h00);
		clkEn <= 1'b1;
		rd(csp_pkg::ADDR_MODE2);
		`CHK(rdv, 8'h01)
		for (int i = 0; i < 10; i++) begin
			code = (i < 4) ? 2'(i) : 2'($urandom);
			d8 = (i == 4) ? 1'b1 : ((i < 4) ? 1'b0 : 1'($urandom));
			wr(csp_pkg::ADDR_CLKCTRL0, {1'b0, d8, 6'h00});
			wr(csp_pkg::ADDR_CLKCTRL1, {code, 6'h20});
			settle();
			`CHK(cpuClkDiv, expDiv(d8, code))
		end
		wr(csp_pkg::ADDR_CLKCTRL0, 8'h00);
		wr(csp_pkg::ADDR_CLKCTRL1, 8'h21);
		settle();
		`CHK({stopMode, feedbackEnable}, 2'h2)
		rd(csp_pkg::ADDR_CLKCTRL0);
		`CHK(rdv[csp_pkg::DIV8_SEL], 1'b1)
		@(posedge clk);
		stopExit <= 1'b1;
		@(posedge clk);
		stopExit <= 1'b0;
		settle();
		`CHK(stopMode, 1'b0)
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h02);
		settle();
		`CHK({cpuClkSrc, ringOscEnable}, {csp_pkg::CSP_SRC_RING, 1'b1})
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h00);
		settle();
		`CHK(cpuClkSrc, csp_pkg::CSP_SRC_MAIN)
		// Monitor on with the ring switch action, then lose the main clock.
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h81);
		@(posedge clk);
		mainOscStopped <= 1'b1;
		oscEvent <= 1'b1;
		#1 `CHK(oscEventIrq, 1'b1)
		@(posedge clk);
		oscEvent <= 1'b0;
		settle();
		`CHK(ringOscEnable, 1'b1)
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h87);
		rd(csp_pkg::ADDR_CLKCTRL2);
		`CHK(rdv[csp_pkg::OSC_EVENT_FLAG], 1'b1)
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h83);
		rd(csp_pkg::ADDR_CLKCTRL2);
		`CHK(rdv[csp_pkg::OSC_EVENT_FLAG], 1'b0)
		@(posedge clk);
		mainOscStopped <= 1'b0;
		wr(csp_pkg::ADDR_CLKCTRL2, 8'h00);
		// The multiplier takes one write only.
		// Reserved bit 4 keeps its reset value of one.
		wr(csp_pkg::ADDR_PLLCTRL, 8'h02);
		wr(csp_pkg::ADDR_PLLCTRL, 8'h04);
		rd(csp_pkg::ADDR_PLLCTRL);
		`CHK(rdv, 8'h12)
		wr(csp_pkg::ADDR_CLKCTRL0, 8'h00);
		wr(csp_pkg::ADDR_PLLCTRL, 8'h82);
		wr(csp_pkg::ADDR_MODE2, 8'h00);
		rd(csp_pkg::ADDR_MODE2);
		`CHK(rdv, 8'h01)
		wr(csp_pkg::ADDR_CLKCTRL1, 8'h22);
		settle();
		`CHK({pllEnable, cpuClkSrc, pllFactor}, {1'b1, csp_pkg::CSP_SRC_PLL, 4'h4})
		wr(csp_pkg::ADDR_CLKCTRL1, 8'h20);
		wr(csp_pkg::ADDR_PLLCTRL, 8'h02);
		wr(csp_pkg::ADDR_MODE2, 8'h05);
		wr(csp_pkg::ADDR_CLKCTRL1, 8'h21);
		settle();
		`CHK({wdtRingSource, ringOscEnable, stopMode}, 3'h6)
		wr(csp_pkg::ADDR_MODE2, 8'h07);
		wr(csp_pkg::ADDR_MODE2, 8'h05);
		rd(csp_pkg::ADDR_MODE2);
		`CHK(rdv[csp_pkg::CLK_CHANGE_LOCK], 1'b1)
		wr(csp_pkg::ADDR_CLKCTRL0, 8'h80);
		wr(csp_pkg::ADDR_PLLCTRL, 8'h80);
		settle();
		`CHK({subOscEnable, pllEnable}, 2'h0)
		rd(csp_pkg::ADDR_PLLCTRL);
		`CHK(rdv, 8'h12)
		wrapUp();
	end
endmodule

bind csp_clock_ctrl csp_clock_ctrl_properties u_props (.clk, .rst_b, .oscEvent, .cpuClkSrc, .cpuClkDiv, .pllFactor,
	.pllEnable, .mainOscEnable, .subOscEnable, .ringOscEnable, .feedbackEnable, .stopMode, .wdtRingSource,
	.regAddr, .regWrite, .oscEventIrq);
